/* File: hdl/lmr_map.vh */
// Purpose: constants for the legacy register map server block
// Assumes: 16-bit registers; channel numbers 1..99; 0/0 marks an unused block
// Notes: included by lmr_top.v and also by the checker and the bench
`ifndef LMR_MAP_VH
`define LMR_MAP_VH
`define LMR_PTR_WORDS 16'h0004
`define LMR_PTR_ZERO 2'h0
`define LMR_PTR_ONE 2'h1
`define LMR_PTR_MAX 2'h2
`define LMR_PTR_MIN 2'h3
`define LMR_RPT_MAX 16'hffff
`define LMR_RPT_MIN 16'h0000
`define LMR_BIT_WORDS 16'h0005
`define LMR_NBITS 16'h0050
`define LMR_COIL_ON 16'hff00
`define LMR_COIL_OFF 16'h0000
`define LMR_K_RDREG 3'h0
`define LMR_K_WRREG 3'h1
`define LMR_K_RDBIT 3'h2
`define LMR_K_WRCOIL 3'h3
`define LMR_K_RDCOIL 3'h4
`define LMR_S_IMM 3'h0
`define LMR_S_AVGI 3'h1
`define LMR_S_AVGF 3'h2
`define LMR_S_FLAG 3'h3
`define LMR_S_QMEM 3'h4
`define LMR_G_BASE 2'h0
`define LMR_G_SECOND_EXTENDED_INTERVAL 2'h1
`define LMR_G_FIRST_EXTENDED_INTERVAL 2'h2
`define LMR_FLAG_B 4'h1
`define LMR_FLAG_U 4'h4
`endif

/* File: hdl/lmr_top.v */
// Purpose: server-side legacy register map: pointer, input and output tables
// Assumes: requests come from a protocol engine on clk_sys; averages come from
//          an averaging engine that answers channel/group lookups in one cycle
// Notes: every request answers with ack_ff two edges after it is taken
`timescale 1ns/10ps
`include "lmr_map.vh"
module lmr_top (
    input wire clk_sys,
    input wire rst,
    input wire req_valid,
    input wire [2:0] req_kind,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    output reg ack_ff,
    output reg err_ff,
    output reg [15:0] rdata_ff,
    input wire [15:0] cfg_addr_base,
    input wire [15:0] cfg_in_base,
    input wire [15:0] cfg_out_base,
    input wire [15:0] pointer_table_config_zero,
    input wire [15:0] pointer_table_config_one,
    input wire [6:0] cfg_int_start,
    input wire [6:0] cfg_int_end,
    input wire [6:0] cfg_flt_start,
    input wire [6:0] cfg_flt_end,
    input wire [79:0] status_pin,
    input wire [79:0] dev_relay_we,
    input wire [79:0] dev_relay_val,
    output reg [79:0] relay_out_ff,
    output reg [6:0] avg_chan_ff,
    output reg [1:0] avg_grp_ff,
    input wire [15:0] avg_int_data,
    input wire [31:0] avg_flt_data,
    input wire [15:0] avg_flag_data,
    input wire scan_tick,
    output reg [98:0] chan_missed_ff,
    output reg q_wr_ff,
    output reg [6:0] q_chan_ff,
    output reg q_float_ff,
    output reg [31:0] q_val_ff
);

    // status pins: three-stage synchroniser, accept when stages two and three agree
    reg [79:0] sts_s1_ff, sts_s2_ff, sts_s3_ff, sts_ff;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sts_s1_ff <= 80'h0;
            sts_s2_ff <= 80'h0;
            sts_s3_ff <= 80'h0;
            sts_ff <= 80'h0;
        end else begin
            sts_s1_ff <= status_pin;
            sts_s2_ff <= sts_s1_ff;
            sts_s3_ff <= sts_s2_ff;
            sts_ff <= (sts_s2_ff & sts_s3_ff) | (sts_ff & (sts_s2_ff ^ sts_s3_ff));
        end
    end

    // block layout from channel configuration
    wire int_used = |{cfg_int_start, cfg_int_end};
    wire flt_used = |{cfg_flt_start, cfg_flt_end};
    wire [7:0] n_int = int_used ? ({1'b0, cfg_int_end} - {1'b0, cfg_int_start} + 8'h01) : 8'h00;
    wire [7:0] n_flt = flt_used ? ({1'b0, cfg_flt_end} - {1'b0, cfg_flt_start} + 8'h01) : 8'h00;
    wire int_first = int_used && (!flt_used || cfg_int_start < cfg_flt_start);
    wire b1_flt = !int_first;
    wire [6:0] b1_st = int_first ? cfg_int_start : cfg_flt_start;
    wire [6:0] b2_st = int_first ? cfg_flt_start : cfg_int_start;
    wire [15:0] b1_n = {8'h00, int_first ? n_int : n_flt};
    wire [15:0] b2_n = {8'h00, int_first ? n_flt : n_int};
    wire [15:0] b1_len = b1_flt ? {b1_n[14:0], 1'b0} : b1_n;
    wire [15:0] b2_len = b1_flt ? b2_n : {b2_n[14:0], 1'b0};
    wire [15:0] vlen = b1_len + b2_len;
    wire [15:0] flen = b1_n + b2_n;
    wire [15:0] glen = vlen + flen;
    wire [15:0] glen2 = {glen[14:0], 1'b0};

    // value word index to {high word, channel}; float channels pair low then high
    function [7:0] val_map;
        input [15:0] idx;
        input flt;
        input [6:0] st;
        begin
            if (flt)
                val_map = {idx[0], st + idx[7:1]};
            else
                val_map = {1'b0, st + idx[6:0]};
        end
    endfunction

    // request decode: address normalise, table select, write strobes
    reg [15:0] eff, aoff, ioff, ooff, r, rr, fi;
    reg d_err, d_hi, d_out_we, d_coil_we, d_coil_val, d_q_we, d_q_flt;
    reg [2:0] d_src, d_out_w;
    reg [1:0] d_grp;
    reg [6:0] d_chan, d_coil_idx;
    reg [7:0] m;
    reg [15:0] d_word;
    always @* begin
        eff = (req_addr < cfg_addr_base) ? req_addr + cfg_addr_base : req_addr;
        aoff = eff - cfg_addr_base;
        ioff = eff - cfg_in_base;
        ooff = eff - cfg_out_base;
        r = ioff - `LMR_BIT_WORDS;
        rr = 16'h0000;
        fi = 16'h0000;
        m = 8'h00;
        d_err = 1'b0;
        d_hi = 1'b0;
        d_out_we = 1'b0;
        d_coil_we = 1'b0;
        d_coil_val = req_wdata == `LMR_COIL_ON;
        d_q_we = 1'b0;
        d_q_flt = 1'b0;
        d_src = `LMR_S_IMM;
        d_out_w = ooff[2:0];
        d_grp = `LMR_G_BASE;
        d_chan = 7'h00;
        d_coil_idx = req_addr[6:0];
        d_word = 16'h0000;
        case (req_kind)
            `LMR_K_RDREG, `LMR_K_WRREG: begin
                if (eff >= cfg_addr_base && aoff < `LMR_PTR_WORDS) begin
                    d_err = req_kind == `LMR_K_WRREG; // read-only
                    case (aoff[1:0])
                        `LMR_PTR_ZERO: d_word = pointer_table_config_zero;
                        `LMR_PTR_ONE: d_word = pointer_table_config_one;
                        `LMR_PTR_MAX: d_word = `LMR_RPT_MAX;
                        default: d_word = `LMR_RPT_MIN;
                    endcase
                end else if (eff >= cfg_in_base && ioff < `LMR_BIT_WORDS) begin
                    d_err = req_kind == `LMR_K_WRREG;
                    d_word = sts_ff[ioff[2:0] * 16 +: 16];
                end else if (eff >= cfg_in_base && r < glen + glen2) begin
                    d_err = req_kind == `LMR_K_WRREG;
                    // groups follow status words: base, second_extended_interval, first_extended_interval
                    if (r < glen) begin
                        d_grp = `LMR_G_BASE;
                        rr = r;
                    end else if (r < glen2) begin
                        d_grp = `LMR_G_SECOND_EXTENDED_INTERVAL;
                        rr = r - glen;
                    end else begin
                        d_grp = `LMR_G_FIRST_EXTENDED_INTERVAL;
                        rr = r - glen2;
                    end
                    if (rr < b1_len) begin
                        m = val_map(rr, b1_flt, b1_st);
                        d_src = b1_flt ? `LMR_S_AVGF : `LMR_S_AVGI;
                    end else if (rr < vlen) begin
                        m = val_map(rr - b1_len, !b1_flt, b2_st);
                        d_src = b1_flt ? `LMR_S_AVGI : `LMR_S_AVGF;
                    end else begin
                        fi = rr - vlen;
                        m = {1'b0, fi < b1_n ? b1_st + fi[6:0] : b2_st + fi[6:0] - b1_n[6:0]};
                        d_src = `LMR_S_FLAG;
                    end
                    d_hi = m[7];
                    d_chan = m[6:0];
                end else if (eff >= cfg_out_base && ooff < `LMR_BIT_WORDS) begin
                    d_word = relay_out_ff[ooff[2:0] * 16 +: 16];
                    d_out_we = req_valid && req_kind == `LMR_K_WRREG;
                end else if (eff >= cfg_out_base && ooff - `LMR_BIT_WORDS < vlen) begin
                    // client-fed base-average inputs
                    rr = ooff - `LMR_BIT_WORDS;
                    if (rr < b1_len) begin
                        m = val_map(rr, b1_flt, b1_st);
                        d_q_flt = b1_flt;
                    end else begin
                        m = val_map(rr - b1_len, !b1_flt, b2_st);
                        d_q_flt = !b1_flt;
                    end
                    d_hi = m[7];
                    d_chan = m[6:0];
                    d_src = `LMR_S_QMEM;
                    d_q_we = req_valid && req_kind == `LMR_K_WRREG;
                end else begin
                    d_err = 1'b1;
                end
            end
            `LMR_K_RDBIT: begin
                // relative, zero based
                d_err = req_addr >= `LMR_NBITS;
                d_word = {15'h0000, sts_ff[req_addr[6:0]]};
            end
            `LMR_K_WRCOIL: begin
                d_err = req_addr >= `LMR_NBITS ||
                    (req_wdata != `LMR_COIL_ON && req_wdata != `LMR_COIL_OFF);
                d_coil_we = req_valid && !d_err;
            end
            default: d_err = 1'b1; // single coil read refused
        endcase
    end

    // relays: device control first, client writes override it
    reg [79:0] nxt_relay;
    always @* begin
        nxt_relay = (relay_out_ff & ~dev_relay_we) | (dev_relay_val & dev_relay_we);
        if (d_out_we)
            nxt_relay[d_out_w * 16 +: 16] = req_wdata;
        if (d_coil_we)
            nxt_relay[d_coil_idx] = d_coil_val;
    end

    // client-fed value storage, one 32-bit pair per channel
    reg [31:0] q_mem_ff [0:98];
    wire [6:0] wr_idx = d_chan - 7'h01;
    integer k;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (k = 0; k < 99; k = k + 1)
                q_mem_ff[k] <= 32'h0;
        end else if (d_q_we) begin
            if (d_hi)
                q_mem_ff[wr_idx][31:16] <= req_wdata;
            else
                q_mem_ff[wr_idx][15:0] <= req_wdata;
        end
    end

    // missed-update tracking per channel over each scan interval
    reg [98:0] upd_ff;
    wire [98:0] fed_w;
    wire [98:0] hit_w;
    genvar gi;
    generate
        for (gi = 0; gi < 99; gi = gi + 1) begin : g_chan
            localparam integer CH = gi + 1;
            assign fed_w[gi] = (int_used && CH >= cfg_int_start && CH <= cfg_int_end) ||
                (flt_used && CH >= cfg_flt_start && CH <= cfg_flt_end);
            assign hit_w[gi] = d_q_we && d_chan == CH;
        end
    endgenerate

    // one register bank keeps a single driver; a write in the tick cycle
    // counts for the closing interval
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            upd_ff <= 99'h0;
            chan_missed_ff <= 99'h0;
        end else if (scan_tick) begin
            upd_ff <= 99'h0;
            chan_missed_ff <= fed_w & ~(upd_ff | hit_w);
        end else begin
            upd_ff <= upd_ff | hit_w;
        end
    end

    // pipeline: stage one looks up averages, stage two answers
    reg p_valid_ff, p_err_ff, p_hi_ff;
    reg [2:0] p_src_ff;
    reg [15:0] p_word_ff;
    wire [6:0] p_idx = avg_chan_ff - 7'h01;
    wire [31:0] p_q = q_mem_ff[p_idx];
    reg [15:0] nxt_rdata;
    always @* begin
        case (p_src_ff)
            `LMR_S_AVGI: nxt_rdata = avg_int_data;
            `LMR_S_AVGF: nxt_rdata = p_hi_ff ? avg_flt_data[31:16] : avg_flt_data[15:0];
            `LMR_S_FLAG: begin
                nxt_rdata = avg_flag_data;
                if (avg_grp_ff == `LMR_G_BASE && chan_missed_ff[p_idx]) begin
                    nxt_rdata[`LMR_FLAG_B] = 1'b1;
                    nxt_rdata[`LMR_FLAG_U] = 1'b1;
                end
            end
            `LMR_S_QMEM: nxt_rdata = p_hi_ff ? p_q[31:16] : p_q[15:0];
            default: nxt_rdata = p_word_ff;
        endcase
    end

    // request pipeline and client-fed write announcement
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            p_valid_ff <= 1'b0;
            p_err_ff <= 1'b0;
            p_hi_ff <= 1'b0;
            p_src_ff <= `LMR_S_IMM;
            p_word_ff <= 16'h0000;
            avg_chan_ff <= 7'h00;
            avg_grp_ff <= `LMR_G_BASE;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            relay_out_ff <= 80'h0;
            q_wr_ff <= 1'b0;
            q_chan_ff <= 7'h00;
            q_float_ff <= 1'b0;
            q_val_ff <= 32'h0;
        end else begin
            p_valid_ff <= req_valid;
            p_err_ff <= d_err;
            p_hi_ff <= d_hi;
            p_src_ff <= d_src;
            p_word_ff <= d_word;
            avg_chan_ff <= d_chan;
            avg_grp_ff <= d_grp;
            ack_ff <= p_valid_ff;
            err_ff <= p_valid_ff && p_err_ff;
            rdata_ff <= (p_valid_ff && !p_err_ff) ? nxt_rdata : 16'h0000;
            relay_out_ff <= nxt_relay;
            q_wr_ff <= d_q_we;
            if (d_q_we) begin
                q_chan_ff <= d_chan;
                q_float_ff <= d_q_flt;
                if (!d_q_flt)
                    q_val_ff <= {16'h0000, req_wdata};
                else if (d_hi)
                    q_val_ff <= {req_wdata, q_mem_ff[wr_idx][15:0]};
                else
                    q_val_ff <= {q_mem_ff[wr_idx][31:16], req_wdata};
            end
        end
    end

endmodule // lmr_top

/* File: dv/lmr_chk.sv */
// Purpose: port-level assertions for lmr_top
// Assumes: one clock domain, rst async high
// Notes: q-write check assumes the integer block starts at channel 1
`timescale 1ns/10ps
`include "lmr_map.vh"
module lmr_chk (
    input wire clk_sys,
    input wire rst,
    input wire req_valid,
    input wire [2:0] req_kind,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    input wire ack_ff,
    input wire err_ff,
    input wire [15:0] rdata_ff,
    input wire [15:0] cfg_addr_base,
    input wire [15:0] cfg_out_base,
    input wire [15:0] pointer_table_config_zero,
    input wire [79:0] relay_out_ff,
    input wire scan_tick,
    input wire [98:0] chan_missed_ff,
    input wire q_wr_ff,
    input wire [6:0] q_chan_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire rd_reg = req_valid && req_kind == `LMR_K_RDREG;
    wire wr_reg = req_valid && req_kind == `LMR_K_WRREG;
    wire in_ptr = (req_addr - cfg_addr_base) < 16'h0004 || req_addr < 16'h0004;
    wire coil_on = req_valid && req_kind == `LMR_K_WRCOIL && req_addr < `LMR_NBITS
        && req_wdata == `LMR_COIL_ON;
    // answers come two edges after the request, never otherwise
    property p_ack; req_valid |-> ##2 ack_ff; endproperty
    a_ack: assert property (p_ack) else $error("answer missing");
    property p_spur; ack_ff |-> $past(req_valid, 2); endproperty
    a_spur: assert property (p_spur) else $error("answer without request");
    property p_ptr0;
        rd_reg && req_addr == cfg_addr_base |->
            ##2 !err_ff && rdata_ff == $past(pointer_table_config_zero, 2);
    endproperty
    a_ptr0: assert property (p_ptr0) else $error("pointer word 0 wrong");
    property p_pmax; rd_reg && req_addr == cfg_addr_base + 16'h0002 |-> ##2 rdata_ff == 16'hffff;
    endproperty
    a_pmax: assert property (p_pmax) else $error("pointer max wrong");
    property p_pwr; wr_reg && in_ptr |-> ##2 ack_ff && err_ff; endproperty
    a_pwr: assert property (p_pwr) else $error("pointer write accepted");
    property p_crd; req_valid && req_kind == `LMR_K_RDCOIL |-> ##2 err_ff; endproperty
    a_crd: assert property (p_crd) else $error("coil read accepted");
    property p_bidx;
        req_valid && req_kind == `LMR_K_RDBIT && req_addr >= `LMR_NBITS |-> ##2 err_ff;
    endproperty
    a_bidx: assert property (p_bidx) else $error("status index out of range accepted");
    // client coil wins over device control in the same cycle
    property p_con; coil_on |=> relay_out_ff[$past(req_addr)]; endproperty
    a_con: assert property (p_con) else $error("coil not driven");
    property p_qwr;
        wr_reg && req_addr == cfg_out_base + 16'h0005 |=> q_wr_ff && q_chan_ff == 7'h01;
    endproperty
    a_qwr: assert property (p_qwr) else $error("client-fed write lost");
    property p_miss; $changed(chan_missed_ff) |-> $past(scan_tick); endproperty
    a_miss: assert property (p_miss) else $error("miss flags moved off tick");
    c_con: cover property (coil_on);
    c_qwr: cover property (q_wr_ff);
    c_err: cover property (ack_ff && err_ff);
endmodule // lmr_chk
bind lmr_top lmr_chk u_chk (.clk_sys, .rst, .req_valid, .req_kind, .req_addr, .req_wdata,
    .ack_ff, .err_ff, .rdata_ff, .cfg_addr_base, .cfg_out_base, .pointer_table_config_zero,
    .relay_out_ff, .scan_tick, .chan_missed_ff, .q_wr_ff, .q_chan_ff);

/* File: dv/lmr_client.sv */
// Purpose: client model driving the request bus one transfer at a time
// Assumes: answer two edges after the taking edge
// Notes: released address and data lines show the inverse of the last value; kind is held
`timescale 1ns/10ps
module lmr_client (
    input wire clk_sys,
    input wire ack_ff,
    input wire err_ff,
    input wire [15:0] rdata_ff,
    output reg req_valid,
    output reg [2:0] req_kind,
    output reg [15:0] req_addr,
    output reg [15:0] req_wdata
);
    initial begin
        req_valid = 1'b0;
        req_kind = 3'h0;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
    end
    // r is {err, data}; all ones if no answer came
    task xfer(input [2:0] k, input [15:0] a, input [15:0] d, output [16:0] r);
        integer i;
        begin
            @(posedge clk_sys);
            req_valid <= 1'b1;
            req_kind <= k;
            req_addr <= a;
            req_wdata <= d;
            @(posedge clk_sys);
            req_valid <= 1'b0;
            req_addr <= ~a;
            req_wdata <= ~d;
            r = 17'h1ffff;
            for (i = 0; i < 4; i = i + 1) begin
                @(negedge clk_sys);
                if (ack_ff === 1'b1) begin
                    r = {err_ff, rdata_ff};
                    i = 4;
                end
            end
        end
    endtask
endmodule // lmr_client

/* File: dv/test_legacy_modbus_register_map.sv */
// Purpose: self-checking bench for lmr_top
// Assumes: integer block 1..64, float block 65..99, default table bases
// Notes: averaging engine answers from a closed-form pattern
`timescale 1ns/10ps
`include "lmr_map.vh"
module test_legacy_modbus_register_map;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [15:0] cfg_addr_base = 16'h9c41, cfg_in_base = 16'h9c45, cfg_out_base = 16'ha02d;
    reg [15:0] pointer_table_config_zero = 16'h0001, pointer_table_config_one = 16'h03e9;
    reg [6:0] cfg_int_start = 7'h01, cfg_int_end = 7'h40, cfg_flt_start = 7'h41;
    reg [6:0] cfg_flt_end = 7'h63;
    reg [79:0] status_pin = 80'h0, dev_relay_we = 80'h0, dev_relay_val = 80'h0, m_relay = 80'h0;
    reg scan_tick = 1'b0;
    reg [31:0] rnd = 32'h26ffa540, last_val = 32'h0, f;
    reg [6:0] last_chan = 7'h0;
    reg last_flt = 1'b0, relay_won = 1'b0;
    reg [16:0] r;
    reg [15:0] d;
    integer miscompares = 0, n_tests = 0, i, c, g, a;
    wire req_valid, ack_ff, err_ff, q_wr_ff, q_float_ff;
    wire [2:0] req_kind;
    wire [15:0] req_addr, req_wdata, rdata_ff;
    wire [79:0] relay_out_ff;
    wire [6:0] avg_chan_ff, q_chan_ff;
    wire [1:0] avg_grp_ff;
    wire [98:0] chan_missed_ff;
    wire [31:0] q_val_ff;
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // averaging engine pattern: value, float pair and flags per channel and group
    function [15:0] mi(input [6:0] ch, input [1:0] gr);
        mi = {gr, 7'h2a, ch};
    endfunction
    function [31:0] mf(input [6:0] ch, input [1:0] gr);
        mf = {~mi(ch, gr), mi(ch, gr)};
    endfunction
    function [15:0] mg(input [6:0] ch, input [1:0] gr);
        mg = {gr, ch, 7'h00};
    endfunction
    wire [15:0] avg_int_data = mi(avg_chan_ff, avg_grp_ff);
    wire [31:0] avg_flt_data = mf(avg_chan_ff, avg_grp_ff);
    wire [15:0] avg_flag_data = mg(avg_chan_ff, avg_grp_ff);
    always #4 clk_sys = ~clk_sys;
    // latch the client-fed strobe contents for later comparison
    always @(posedge clk_sys) if (q_wr_ff === 1'b1) begin
        last_chan <= q_chan_ff;
        last_flt <= q_float_ff;
        last_val <= q_val_ff;
    end
    // bit 0 seen high while the device drives every relay low
    always @(posedge clk_sys) if (dev_relay_we[0] && relay_out_ff[0] === 1'b1) relay_won <= 1'b1;
    lmr_client cli (.clk_sys, .ack_ff, .err_ff, .rdata_ff, .req_valid, .req_kind, .req_addr,
        .req_wdata);
    lmr_top uut (.clk_sys, .rst, .req_valid, .req_kind, .req_addr, .req_wdata, .ack_ff,
        .err_ff, .rdata_ff, .cfg_addr_base, .cfg_in_base, .cfg_out_base,
        .pointer_table_config_zero, .pointer_table_config_one, .cfg_int_start, .cfg_int_end,
        .cfg_flt_start, .cfg_flt_end, .status_pin, .dev_relay_we, .dev_relay_val,
        .relay_out_ff, .avg_chan_ff, .avg_grp_ff, .avg_int_data, .avg_flt_data,
        .avg_flag_data, .scan_tick, .chan_missed_ff, .q_wr_ff, .q_chan_ff, .q_float_ff,
        .q_val_ff);
    task chk(input [98:0] got, input [98:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // full answer compare; writes only check that no error came back
    task rd(input [2:0] k, input integer adr, input [15:0] wd, input [16:0] exp);
        begin
            cli.xfer(k, adr[15:0], wd, r);
            chk({82'h0, r}, {82'h0, exp});
        end
    endtask
    task wr(input [2:0] k, input integer adr, input [15:0] wd);
        begin
            cli.xfer(k, adr[15:0], wd, r);
            chk({98'h0, r[16]}, 99'h0);
        end
    endtask
    task tick;
        begin
            @(posedge clk_sys);
            scan_tick <= 1'b1;
            @(posedge clk_sys);
            scan_tick <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        miscompares = miscompares + 1;
        end_of_test;
    end
    initial begin
        rnd = xs(rnd);
        pointer_table_config_zero = rnd[15:0];
        pointer_table_config_one = rnd[31:16];
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        // pointer words, absolute and as index below the base
        for (i = 0; i < 4; i = i + 1) begin
            d = i == 0 ? pointer_table_config_zero : i == 1 ? pointer_table_config_one :
                i == 2 ? 16'hffff : 16'h0000;
            rd(`LMR_K_RDREG, cfg_addr_base + i, 16'h0, {1'b0, d});
            rd(`LMR_K_RDREG, i, 16'h0, {1'b0, d});
        end
        rd(`LMR_K_WRREG, cfg_addr_base + 1, 16'h1234, 17'h10000);
        $display("end of pointer test");
        rnd = xs(rnd);
        status_pin <= {rnd[15:0], rnd, ~rnd};
        repeat (6) @(posedge clk_sys);
        for (i = 0; i < 5; i = i + 1) begin
            d = status_pin[16*i +: 16];
            rd(`LMR_K_RDREG, cfg_in_base + i, 16'h0, {1'b0, d});
        end
        for (i = 0; i < 8; i = i + 1) begin
            rnd = xs(rnd);
            c = rnd % 80;
            rd(`LMR_K_RDBIT, c, 16'h0, {16'h0, status_pin[c]});
        end
        rd(`LMR_K_RDBIT, 80, 16'h0, 17'h10000);
        $display("end of status test");
        // random channel and group; the group stride is 64 + 70 + 99 registers
        for (i = 0; i < 14; i = i + 1) begin
            rnd = xs(rnd);
            c = rnd[15:0] % 99 + 1;
            g = rnd[17:16] % 3;
            a = cfg_in_base + 5 + 233 * g;
            f = mf(c[6:0], g[1:0]);
            if (c < 65) rd(`LMR_K_RDREG, a + c - 1, 16'h0, {1'b0, f[15:0]});
            else begin
                rd(`LMR_K_RDREG, a + 64 + 2 * (c - 65), 16'h0, {1'b0, f[15:0]});
                rd(`LMR_K_RDREG, a + 65 + 2 * (c - 65), 16'h0, {1'b0, f[31:16]});
            end
            rd(`LMR_K_RDREG, a + 133 + c, 16'h0, {1'b0, mg(c[6:0], g[1:0])});
        end
        rd(`LMR_K_RDREG, cfg_in_base + 704, 16'h0, 17'h10000);
        $display("end of average test");
        for (i = 0; i < 5; i = i + 1) begin
            rnd = xs(rnd);
            wr(`LMR_K_WRREG, cfg_out_base + i, rnd[15:0]);
            m_relay[16*i +: 16] = rnd[15:0];
            chk({19'h0, relay_out_ff}, {19'h0, m_relay});
            rd(`LMR_K_RDREG, cfg_out_base + i, 16'h0, {1'b0, rnd[15:0]});
        end
        for (i = 0; i < 8; i = i + 1) begin
            rnd = xs(rnd);
            c = rnd % 80;
            wr(`LMR_K_WRCOIL, c, rnd[8] ? `LMR_COIL_ON : `LMR_COIL_OFF);
            m_relay[c] = rnd[8];
            chk({19'h0, relay_out_ff}, {19'h0, m_relay});
        end
        rd(`LMR_K_WRCOIL, 3, 16'h1234, 17'h10000);
        rd(`LMR_K_RDCOIL, 3, 16'h0, 17'h10000);
        rd(`LMR_K_WRCOIL, 80, `LMR_COIL_ON, 17'h10000);
        chk({19'h0, relay_out_ff}, {19'h0, m_relay});
        // device holds relays low while the client forces one on
        dev_relay_we <= {80{1'b1}};
        repeat (2) @(posedge clk_sys);
        relay_won <= 1'b0;
        wr(`LMR_K_WRCOIL, 0, `LMR_COIL_ON);
        chk({19'h0, relay_out_ff}, 99'h0);
        chk({98'h0, relay_won}, 99'h1);
        dev_relay_we <= 80'h0;
        $display("end of output test");
        // only channels 5 and 70 are fed this interval
        tick;
        rnd = xs(rnd);
        wr(`LMR_K_WRREG, cfg_out_base + 9, rnd[15:0]);
        chk({59'h0, last_flt, last_chan, last_val}, {59'h0, 1'b0, 7'h05, 16'h0, rnd[15:0]});
        wr(`LMR_K_WRREG, cfg_out_base + 79, rnd[15:0]);
        wr(`LMR_K_WRREG, cfg_out_base + 80, rnd[31:16]);
        chk({59'h0, last_flt, last_chan, last_val}, {59'h0, 1'b1, 7'h46, rnd});
        tick;
        chk({96'h0, chan_missed_ff[69], chan_missed_ff[5:4]}, 99'h2);
        rd(`LMR_K_RDREG, cfg_in_base + 144, 16'h0, {1'b0, mg(7'h06, 2'h0) | 16'h0012});
        rd(`LMR_K_RDREG, cfg_in_base + 143, 16'h0, {1'b0, mg(7'h05, 2'h0)});
        $display("end of client-fed test");
        end_of_test;
    end
endmodule // test_legacy_modbus_register_map
